//--- common/pfam_nv_if.sv
/*
  pfam_nv_if: port between the monitor and its retained position store.
  Assumes: single clock; read data registered one cycle after addr.
*/
`timescale 1ns/10ps
`default_nettype none
interface pfam_nv_if;
  logic we;
  logic [1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport ctl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface: pfam_nv_if
`default_nettype wire

//--- common/pfam_pkg.sv
/*
  pfam_pkg: constants, register map and state codes of the position
  feedback absolute monitor.
  Assumes: APB byte addresses, 32-bit data, one clock at 125 MHz.
*/
package pfam_pkg;
  // clocking and cyclic acquisition
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned ACQ_NS = 1000;
  localparam int unsigned ACQ_CYC = (ACQ_NS * CLK_MHZ) / 1000;
  localparam int unsigned ACQ_W = $clog2(ACQ_CYC);
  // register byte offsets
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_LINES = 8'h04;
  localparam logic [7:0] A_MULT = 8'h08;
  localparam logic [7:0] A_DCR1 = 8'h0C;
  localparam logic [7:0] A_DCR2 = 8'h10;
  localparam logic [7:0] A_REFDES = 8'h14;
  localparam logic [7:0] A_WIN = 8'h18;
  localparam logic [7:0] A_CMD = 8'h1C;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_RES = 8'h24;
  localparam logic [7:0] A_POS = 8'h28;
  localparam logic [7:0] A_RANGE = 8'h2C;
  // feedback type field positions
  localparam int unsigned CF_LIN = 0;
  localparam int unsigned CF_DC = 1;
  localparam int unsigned CF_SQ = 2;
  localparam int unsigned CF_MT = 3;
  // command bits
  localparam int unsigned CM_SET = 0;
  localparam int unsigned CM_CLR = 1;
  // reset values
  localparam logic [5:0] CFG_RST = 6'h08;
  localparam logic [23:0] LINES_RST = 24'h000400;
  localparam logic [7:0] MULT_RST = 8'h01;
  localparam logic [31:0] WIN_RST = 32'h00000100;
  // detection range limits in pitch units
  localparam logic [31:0] RNG_SQ = 32'h20000000;
  localparam logic [31:0] RNG_SIN = 32'h00040000;
  // error code reported for an absolute encoder mismatch
  localparam logic [7:0] ERR_ABS = 8'h4C;
  // retained store word addresses
  localparam logic [1:0] NV_POS = 2'h0;
  localparam logic [1:0] NV_OFS = 2'h1;
  // sequencer states
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_RD0 = 7'h02,
    ST_RD1 = 7'h04,
    ST_CHK = 7'h08,
    ST_RUN = 7'h10,
    ST_SV0 = 7'h20,
    ST_SV1 = 7'h40
  } pfam_state_e;
endpackage: pfam_pkg

//--- rtl/pfam_monitor.sv
/*
  pfam_monitor: external feedback configuration, resolution and range,
  absolute multiturn reference and restart position check, APB slave.
  Assumes: enc_pos stable while enc_stb is high; drive_on and enc_stb
  are asynchronous pins; NC software drives the APB master.
*/
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - feedback type bit 0 picks linear scale (1) or rotary encoder (0).
// - type bit 1 selects distance-coded marks; both coded dimensions must be set.
// - rotary resolution: lines, or lines times external multiplication for square.
// - linear resolution: grid, or grid divided by external multiplication for square.
// - square-wave signals give detection range of plus or minus 2^29 pitch units.
// - sine-wave signals limit detection range to plus or minus 2^18 pitch units.
// - multiturn option acquires absolute rotor position cyclically over 4096 turns.
// - absolute drive presents a valid reference at power-up without homing.
// - jog, write position, set-absolute command, drop enable; applied at restart.
// - store position at switch-off; restart mismatch beyond window gives error 76.
// - travel beyond detection range marks absolute position as lost.
// - after NC clears error 76, position inside window means feedback error.
module pfam_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // position encoder
  input wire logic [31:0] enc_pos,
  input wire logic enc_stb,
  output logic enc_req,
  // drive power and nc status
  input wire logic drive_on,
  output logic [7:0] err_code,
  output logic abs_err,
  output logic pos_lost,
  output logic fb_err,
  output logic ref_valid,
  output logic [31:0] act_pos
);
  import pfam_pkg::*;

  localparam int AQ_GAP = ACQ_CYC;

  default clocking dc @(posedge clk); endclocking
  default disable iff rst;

  function automatic logic [31:0] mag32(input logic [31:0] v);
    return v[31] ? (~v + 32'h00000001) : v;
  endfunction: mag32

  pfam_nv_if nv ();
  pfam_nv_mem u_mem (
    .clk(clk),
    .nv(nv)
  );

  pfam_state_e st_q, st_d;
  logic [5:0] cfg_q;
  logic [23:0] lines_q;
  logic [7:0] mult_q;
  logic [31:0] dcr1_q, dcr2_q, ref_des_q, win_q;
  logic [31:0] res_q, range_q, raw_q, offset_q, stored_q, act_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q, enc_req_q;
  logic err76_q, lost_q, fb_err_q, ref_valid_q, pend_q, nv_ok_q;
  logic [7:0] err_code_q;
  logic [ACQ_W-1:0] acq_cnt_q;

  // pin synchronisers: drive_on is bit 0, enc_stb is bit 1
  logic [1:0] pin_in, lvl, rise;
  assign pin_in = {enc_stb, drive_on};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    logic s1_q, s2_q, s3_q, lvl_q;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        lvl_q <= 1'b0;
      end else begin
        s1_q <= pin_in[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end
    end
    assign lvl[i] = lvl_q;
    assign rise[i] = s2_q & s3_q & ~lvl_q;
  end

  wire drv_lvl = lvl[0];
  wire smp_ev = rise[1];

  // apb decode: one wait state, answer from registers
  wire acc = psel & penable;
  wire fire = acc & pready_q;
  wire wr_fire = fire & pwrite;
  wire hit_cfg = (paddr == A_CFG);
  wire hit_lines = (paddr == A_LINES);
  wire hit_mult = (paddr == A_MULT);
  wire hit_dcr1 = (paddr == A_DCR1);
  wire hit_dcr2 = (paddr == A_DCR2);
  wire hit_ref = (paddr == A_REFDES);
  wire hit_win = (paddr == A_WIN);
  wire hit_cmd = (paddr == A_CMD);
  wire hit_stat = (paddr == A_STAT);
  wire hit_res = (paddr == A_RES);
  wire hit_pos = (paddr == A_POS);
  wire hit_rng = (paddr == A_RANGE);
  wire map_hit = hit_cfg | hit_lines | hit_mult | hit_dcr1 | hit_dcr2 | hit_ref
               | hit_win | hit_cmd | hit_stat | hit_res | hit_pos | hit_rng;
  wire set_fire = wr_fire & hit_cmd & pwdata[CM_SET] & st_q[4];
  wire clr_fire = wr_fire & hit_cmd & pwdata[CM_CLR];

  // feedback type decode
  wire is_lin = cfg_q[CF_LIN];
  wire is_sq = cfg_q[CF_SQ];
  wire is_mt = cfg_q[CF_MT];
  // coded marks need both dimensions; flagged until software supplies them
  wire dc_miss = cfg_q[CF_DC] & ((dcr1_q == 32'h00000000) | (dcr2_q == 32'h00000000));

  wire [31:0] status = {17'h00000, st_q[4], dc_miss, pend_q, ref_valid_q, fb_err_q,
                        lost_q, err76_q, err_code_q};
  wire [31:0] rd_data =
      hit_cfg ? {26'h0000000, cfg_q} :
      hit_lines ? {8'h00, lines_q} :
      hit_mult ? {24'h000000, mult_q} :
      hit_dcr1 ? dcr1_q :
      hit_dcr2 ? dcr2_q :
      hit_ref ? ref_des_q :
      hit_win ? win_q :
      hit_stat ? status :
      hit_res ? res_q :
      hit_pos ? act_q :
      hit_rng ? range_q : 32'h00000000;

  // bus answer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~map_hit;
      prdata_q <= (acc & ~pready_q & ~pwrite) ? rd_data : 32'h00000000;
    end
  end

  // pready_q rises one edge after the first access-phase edge
  a_apb_one_wait: assert property (psel && !penable ##1 acc |=> pready_q)
    else $error("apb access phase not answered after one wait");

  // configuration registers written at the completing edge only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_q <= CFG_RST;
      lines_q <= LINES_RST;
      mult_q <= MULT_RST;
      dcr1_q <= 32'h00000000;
      dcr2_q <= 32'h00000000;
      ref_des_q <= 32'h00000000;
      win_q <= WIN_RST;
    end else if (wr_fire) begin
      if (hit_cfg) cfg_q <= pwdata[5:0];
      if (hit_lines) lines_q <= pwdata[23:0];
      if (hit_mult) mult_q <= pwdata[7:0];
      if (hit_dcr1) dcr1_q <= pwdata;
      if (hit_dcr2) dcr2_q <= pwdata;
      if (hit_ref) ref_des_q <= pwdata;
      if (hit_win) win_q <= pwdata;
    end
  end

  // resolution and range; a zero multiplier counts as one in the linear divide only, to avoid divide by zero
  wire [7:0] mult_nz = (mult_q == 8'h00) ? 8'h01 : mult_q;
  wire [31:0] res_rot_sq = {8'h00, lines_q} * {24'h000000, mult_q};
  wire [31:0] res_lin_sq = {8'h00, lines_q} / {24'h000000, mult_nz};
  wire [31:0] res_d = is_lin ? (is_sq ? res_lin_sq : {8'h00, lines_q})
                             : (is_sq ? res_rot_sq : {8'h00, lines_q});
  wire [31:0] range_d = is_sq ? RNG_SQ : RNG_SIN;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_q <= 32'h00000000;
      range_q <= RNG_SIN;
    end else begin
      res_q <= res_d;
      range_q <= range_d;
    end
  end

  a_res_rot_sine: assert property (!is_lin && !is_sq |=> res_q == {8'h00, $past(lines_q)})
    else $error("rotary sine resolution is not the line count");
  a_res_rot_square: assert property (!is_lin && is_sq |=>
      res_q == {8'h00, $past(lines_q)} * {24'h000000, $past(mult_q)})
    else $error("rotary square resolution is not lines times multiplication");
  a_res_lin_square: assert property (is_lin && is_sq && mult_q != 8'h00 |=>
      res_q == {8'h00, $past(lines_q)} / {24'h000000, $past(mult_q)})
    else $error("linear square resolution is not grid over multiplication");
  a_range_square: assert property (is_sq |=> range_q == 32'h20000000)
    else $error("square-wave range is not 2^29");
  a_range_sine: assert property (!is_sq |=> range_q == 32'h00040000)
    else $error("sine-wave range is not 2^18");

  // cyclic acquisition divider; request pulse every period
  wire acq_tick = (acq_cnt_q == ACQ_W'(ACQ_CYC - 1));
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acq_cnt_q <= '0;
      enc_req_q <= 1'b0;
      raw_q <= 32'h00000000;
    end else begin
      acq_cnt_q <= acq_tick ? '0 : acq_cnt_q + 1'b1;
      enc_req_q <= acq_tick;
      if (smp_ev) raw_q <= enc_pos;
    end
  end

  a_acq_period: assert property (acq_tick |-> ##AQ_GAP acq_tick)
    else $error("acquisition period wrong");

  // restart check terms: upper 12 bits of raw count turns, wrapping at 4096
  wire [31:0] chk_pos = raw_q + nv.rdata;
  wire [31:0] chk_dev = mag32(chk_pos - stored_q);
  wire chk_live = st_q[3] & ~pend_q & nv_ok_q & is_mt;
  wire mismatch = chk_live & (chk_dev > win_q);
  wire run_dev_ok = (mag32(act_q - stored_q) <= win_q);
  // range test on the next actual value: act_q still carries the old offset
  // for one cycle after the restart check and would trip a false overrun
  wire [31:0] act_d = raw_q + offset_q;
  wire out_rng = st_q[4] & ref_valid_q & (mag32(act_d) > range_q);

  // sequencer: off, read store, check, run, save on switch-off
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_OFF: if (drv_lvl) st_d = ST_RD0;
      ST_RD0: if (smp_ev) st_d = ST_RD1;
      ST_RD1: st_d = ST_CHK;
      ST_CHK: st_d = ST_RUN;
      ST_RUN: if (!drv_lvl) st_d = ST_SV0;
      ST_SV0: st_d = ST_SV1;
      ST_SV1: st_d = ST_OFF;
      default: st_d = ST_OFF;
    endcase
  end

  // store port: position then offset saved at switch-off
  assign nv.we = st_q[5] | st_q[6];
  assign nv.addr = (st_q[2] | st_q[6]) ? NV_OFS : NV_POS;
  assign nv.wdata = st_q[6] ? offset_q : act_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_OFF;
      stored_q <= 32'h00000000;
      act_q <= 32'h00000000;
      nv_ok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      act_q <= act_d;
      if (st_q[2]) stored_q <= nv.rdata;
      if (st_q[6]) nv_ok_q <= 1'b1;
    end
  end

  // reference handling: pending set applies at restart, else reload offset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      offset_q <= 32'h00000000;
      ref_valid_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (st_q[3] && pend_q) begin
      offset_q <= ref_des_q - raw_q;
      ref_valid_q <= 1'b1;
      pend_q <= 1'b0;
    end else if (st_q[3]) begin
      if (nv_ok_q) offset_q <= nv.rdata;
      ref_valid_q <= ref_valid_q & is_mt & ~mismatch;
    end else begin
      if (set_fire) pend_q <= 1'b1;
      if (out_rng) ref_valid_q <= 1'b0;
    end
  end

  a_set_ref: assert property (st_q[3] && pend_q |=>
      ref_valid_q && !pend_q && offset_q == $past(ref_des_q) - $past(raw_q))
    else $error("pending reference not applied at restart");
  a_power_ref: assert property (chk_live && ref_valid_q && !mismatch |=> ref_valid_q)
    else $error("valid reference dropped at power-up");

  // sticky flags; a new event in a clearing cycle wins
  wire fb_set = clr_fire & err76_q & run_dev_ok;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      err76_q <= 1'b0;
      lost_q <= 1'b0;
      fb_err_q <= 1'b0;
      err_code_q <= 8'h00;
    end else begin
      err76_q <= mismatch | (err76_q & ~clr_fire);
      err_code_q <= (mismatch | (err76_q & ~clr_fire)) ? ERR_ABS : 8'h00;
      lost_q <= out_rng | (lost_q & ~clr_fire);
      fb_err_q <= fb_set | (fb_err_q & ~(clr_fire & ~err76_q) & ~(st_q[3] & pend_q));
    end
  end

  a_chk_err: assert property (mismatch |=> err76_q && err_code_q == 8'h4C)
    else $error("restart mismatch did not raise error 76");
  a_err_hold: assert property (err76_q && !clr_fire |=> err76_q)
    else $error("error flag dropped without a clear");
  a_err_code: assert property (err76_q |-> err_code_q == 8'h4C && abs_err)
    else $error("error code not shown with error flag");
  a_lost_range: assert property (out_rng |=> lost_q && !ref_valid_q)
    else $error("range overrun did not mark position lost");
  a_fb_class: assert property (clr_fire && err76_q && run_dev_ok |=> fb_err_q && !err76_q)
    else $error("feedback error not classed after clear");

  c_err76: cover property (st_q[3] ##1 err76_q);
  c_set_ref: cover property (set_fire ##[1:1000] st_q[3] && pend_q);
  c_lost: cover property (out_rng ##1 lost_q);
  c_fb_err: cover property (fb_set ##1 fb_err_q);

  // outputs straight from registers
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign enc_req = enc_req_q;
  assign err_code = err_code_q;
  assign abs_err = err76_q;
  assign pos_lost = lost_q;
  assign fb_err = fb_err_q;
  assign ref_valid = ref_valid_q;
  assign act_pos = act_q;
endmodule: pfam_monitor
`default_nettype wire

//--- rtl/pfam_nv_mem.sv
/*
  pfam_nv_mem: four-word retained store for position and offset.
  Assumes: contents survive drive switch-off; no reset on purpose.
*/
`timescale 1ns/10ps
`default_nettype none
module pfam_nv_mem (
  // clock
  input wire logic clk,
  // store access
  pfam_nv_if.mem nv
);
  logic [31:0] mem_q [4];

  // read first (a write returns the old word), read data always from a register
  always_ff @(posedge clk) begin
    if (nv.we) begin
      mem_q[nv.addr] <= nv.wdata;
    end
    nv.rdata <= mem_q[nv.addr];
  end
endmodule: pfam_nv_mem
`default_nettype wire

//--- tb/pfam_enc_model.sv
/*
  pfam_enc_model: absolute multiturn encoder answering sample requests.
  Assumes: the bench sets the shaft count on pos; one clock with the monitor.
*/
`timescale 1ns/10ps
`default_nettype none
module pfam_enc_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench control
  input wire logic [31:0] pos,
  input wire logic slow,
  // encoder pins
  input wire logic enc_req,
  output logic [31:0] enc_pos,
  output logic enc_stb
);
  logic [3:0] cnt_q;
  logic [3:0] lat;
  // slow mode stretches the answer to exercise the restart wait
  assign lat = slow ? 4'h6 : 4'h2;
  // one strobe of 7 cycles per request; stale word is inverted after it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      enc_stb <= 1'b0;
      enc_pos <= 32'h00000000;
    end else begin
      if (cnt_q != 4'h0 || enc_req) begin
        cnt_q <= cnt_q + 4'h1;
      end
      if (cnt_q == lat) begin
        enc_pos <= pos; // turns in 31:20, positive travel counts up
        enc_stb <= 1'b1;
      end else if (cnt_q == lat + 4'h7) begin
        enc_stb <= 1'b0;
        enc_pos <= ~enc_pos; // nobody may lean on a released word
      end
    end
  end
endmodule: pfam_enc_model
`default_nettype wire

//--- tb/position_feedback_absolute_monitor_test.sv
/*
  position_feedback_absolute_monitor_test: self-checking bench of the monitor.
  Assumes: APB master in this bench, encoder model on the far side.
*/
`timescale 1ns/10ps
`default_nettype none
module position_feedback_absolute_monitor_test;
  import pfam_pkg::*;
  typedef struct packed {logic [5:0] cfg; logic [31:0] res; logic [31:0] rng;} pfam_row_s;
  localparam logic [31:0] BASE = 32'h00A00123;
  logic clk, rst, psel, penable, pwrite, drive_on, slow, pready, pslverr, perr;
  logic enc_stb, enc_req, abs_err, pos_lost, fb_err, ref_valid;
  logic [7:0] paddr, err_code;
  logic [31:0] pwdata, prdata, enc_pos, act_pos, pos, rdat;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int n_req;
  logic [7:0] ra [7] = '{A_CFG, A_LINES, A_MULT, A_WIN, A_STAT, A_RANGE, A_CMD};
  logic [31:0] rv [7] = '{32'h8, 32'h400, 32'h1, 32'h100, 32'h0, RNG_SIN, 32'h0};
  // config rows with lines 0x1200 and multiplication 4
  pfam_row_s rows [5] = '{
    '{6'h08, 32'h00001200, RNG_SIN}, '{6'h0C, 32'h00004800, RNG_SQ},
    '{6'h09, 32'h00001200, RNG_SIN}, '{6'h0D, 32'h00000480, RNG_SQ},
    '{6'h0F, 32'h00000480, RNG_SQ}};
  pfam_monitor u_pfam_monitor (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_pos(enc_pos), .enc_stb(enc_stb), .enc_req(enc_req),
    .drive_on(drive_on), .err_code(err_code), .abs_err(abs_err), .pos_lost(pos_lost),
    .fb_err(fb_err), .ref_valid(ref_valid), .act_pos(act_pos));
  pfam_enc_model u_pfam_enc_model (.clk(clk), .rst(rst), .pos(pos), .slow(slow),
    .enc_req(enc_req), .enc_pos(enc_pos), .enc_stb(enc_stb));
  // 125 MHz clock
  always #4 clk = ~clk;
  task automatic tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask: tally_and_finish
  // hang guard, runs well above the roughly 1500 cycles expected
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask: chk
  // one transfer; an idle edge first keeps each signal to one change per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no assumed latency; only the bench timeout ends a hung transfer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask: apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, perr);
  endtask: wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0, rdat, perr);
    chk(nm, exp, rdat);
  endtask: rdc
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask: tick
  // poll the running status bit, bounded
  task automatic wait_run(input logic want);
    for (int i = 0; i < 100; i++) begin
      apb(1'b0, A_STAT, 32'h0, rdat, perr);
      if (rdat[14] === want) return;
    end
    // running out of polls is a failure, not a silent pass
    failures++;
    $display("mismatch running expected %h seen %h", want, rdat[14]);
  endtask: wait_run
  // switch off, move the shaft while off, switch on again
  task automatic restart(input logic [31:0] p);
    drive_on <= 1'b0;
    wait_run(1'b0);
    pos <= p;
    drive_on <= 1'b1;
    wait_run(1'b1);
    tick(3);
  endtask: restart
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, drive_on, slow} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pos = BASE;
    tick(20);
    rst <= 1'b0;
    // reset values, unmapped and read-only places
    for (int i = 0; i < 7; i++) rdc(ra[i], rv[i], "reset value");
    apb(1'b0, 8'h30, 32'h0, rdat, perr);
    chk("unmapped error", 32'h1, 32'(perr));
    wr(A_RANGE, 32'h0);
    rdc(A_RANGE, RNG_SIN, "range read only");
    // resolution and range per feedback type
    wr(A_LINES, 32'h00001200);
    wr(A_MULT, 32'h00000004);
    foreach (rows[i]) begin
      wr(A_CFG, {26'h0, rows[i].cfg});
      rdc(A_RES, rows[i].res, "resolution");
      rdc(A_RANGE, rows[i].rng, "range");
    end
    // cyclic acquisition: edges from one sample request to the next
    do @(posedge clk); while (enc_req !== 1'b1);
    n_req = 0;
    do begin
      @(posedge clk);
      n_req++;
    end while (enc_req !== 1'b1);
    chk("request period", 32'(ACQ_CYC), 32'(n_req));
    // coded reference dimensions demanded, then supplied
    wr(A_CFG, 32'h0000000B);
    apb(1'b0, A_STAT, 32'h0, rdat, perr);
    chk("dims missing", 32'h1, 32'(rdat[13]));
    wr(A_DCR1, 32'h00000100);
    wr(A_DCR2, 32'h00000140);
    apb(1'b0, A_STAT, 32'h0, rdat, perr);
    chk("dims given", 32'h0, 32'(rdat[13]));
    wr(A_CFG, 32'h00000008);
    wr(A_LINES, 32'h00000400);
    wr(A_MULT, 32'h00000001);
    // set the absolute reference, applied at restart
    drive_on <= 1'b1;
    wait_run(1'b1);
    wr(A_REFDES, 32'h00001000);
    wr(A_CMD, 32'h00000001);
    restart(BASE);
    chk("ref valid", 32'h1, 32'(ref_valid));
    chk("act pos", 32'h00001000, act_pos);
    restart(BASE);
    chk("ref kept", 32'h1, 32'(ref_valid));
    chk("no error", 32'h0, 32'(abs_err));
    // shaft moved beyond the window while off, slow encoder
    slow <= 1'b1;
    restart(BASE + 32'h200);
    chk("abs err", 32'h1, 32'(abs_err));
    chk("err code", 32'(ERR_ABS), 32'(err_code));
    chk("ref dropped", 32'h0, 32'(ref_valid));
    pos <= BASE;
    tick(300);
    chk("err held", 32'h1, 32'(abs_err));
    wr(A_CMD, 32'h00000002);
    tick(2);
    chk("err cleared", 32'h0, 32'(abs_err));
    chk("code cleared", 32'h0, 32'(err_code));
    chk("feedback err", 32'h1, 32'(fb_err));
    // re-reference near the sine range edge, then overrun it
    slow <= 1'b0;
    wr(A_REFDES, 32'h0003FF00);
    wr(A_CMD, 32'h00000001);
    restart(BASE);
    chk("fb err reset", 32'h0, 32'(fb_err));
    chk("new ref", 32'h0003FF00, act_pos);
    pos <= BASE + 32'h200;
    tick(300);
    chk("pos lost", 32'h1, 32'(pos_lost));
    chk("lost ref", 32'h0, 32'(ref_valid));
    wr(A_CMD, 32'h00000002);
    tick(2);
    chk("lost cleared", 32'h0, 32'(pos_lost));
    tally_and_finish();
  end
endmodule: position_feedback_absolute_monitor_test
`default_nettype wire
